// >>> core/dio_pkg.sv
package dio_pkg;
    // Line counts
    localparam int DIO_LINES = 32;
    localparam int DIO_STD_LINES = 8;
    localparam int DIO_STD_BIDIR = 4;
    // Clock period in picoseconds (200 MHz)
    localparam longint DIO_CLK_PS = 5000;
    // Refresh periods, in their own units as printed
    localparam longint DIO_FAST_US = 500;
    localparam longint DIO_FAST_RED_MS = 30;
    localparam longint DIO_STD_MS = 4;
    localparam longint DIO_STD_RED_MS = 750;
    localparam longint DIO_PS_PER_US = 1000000;
    localparam longint DIO_PS_PER_MS = 1000000000;
    // Derived refresh counts in clock cycles (longest-time style, rounded down)
    localparam int DIO_FAST_CYC = int'(DIO_FAST_US * DIO_PS_PER_US / DIO_CLK_PS);
    localparam int DIO_FAST_RED_CYC = int'(DIO_FAST_RED_MS * DIO_PS_PER_MS / DIO_CLK_PS);
    localparam int DIO_STD_CYC = int'(DIO_STD_MS * DIO_PS_PER_MS / DIO_CLK_PS);
    localparam int DIO_STD_RED_CYC = int'(DIO_STD_RED_MS * DIO_PS_PER_MS / DIO_CLK_PS);
    // Width of the refresh counters
    localparam int DIO_CNT_W = 32;
    // Reset values
    localparam logic [31:0] DIO_WORD_RST = 32'h00000000;
    localparam logic [7:0] DIO_BYTE_RST = 8'h00;
endpackage

// >>> core/dio_port.sv
`timescale 1ns/1ps
module dio_port
    import dio_pkg::*;
#(
    parameter int N_LINES = dio_pkg::DIO_LINES,
    parameter int FAST_CYC = dio_pkg::DIO_FAST_CYC,
    parameter int FAST_RED_CYC = dio_pkg::DIO_FAST_RED_CYC,
    parameter int STD_CYC = dio_pkg::DIO_STD_CYC,
    parameter int STD_RED_CYC = dio_pkg::DIO_STD_RED_CYC
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Host variant strap, same clock domain
    input wire logic REDUCED_HOST,
    // Fast path words from the host-selected parameters
    input wire logic [N_LINES-1:0] DIRECTION_WORD,
    input wire logic [N_LINES-1:0] OUTPUT_VALUE_WORD,
    output logic [N_LINES-1:0] LINE_STATE_WORD,
    // Standard path settings and data for lines one to eight
    input wire logic [dio_pkg::DIO_STD_LINES-1:0] STD_ROUTED,
    input wire logic [dio_pkg::DIO_STD_LINES-1:0] STD_INVERT,
    input wire logic [dio_pkg::DIO_STD_BIDIR-1:0] STD_OUTPUT_SELECT,
    input wire logic [dio_pkg::DIO_STD_BIDIR-1:0] STD_SOURCE_VALUE,
    output logic [dio_pkg::DIO_STD_LINES-1:0] STD_DEST_VALUE,
    // Line pins
    input wire logic [N_LINES-1:0] LINE_IN,
    output logic [N_LINES-1:0] LINE_OUT,
    output logic [N_LINES-1:0] LINE_OE,
    // Overload protection
    input wire logic LINE_OVERLOAD,
    input wire logic AUX_OVERLOAD,
    input wire logic TRIP_CLEAR,
    output logic AUX_SUPPLY_OUTPUT_EN,
    output logic OVERLOAD_TRIP,
    // Refresh strobes for the host
    output logic FAST_REFRESH,
    output logic STD_REFRESH
);
    localparam int NS = DIO_STD_LINES;
    localparam int NB = DIO_STD_BIDIR;

    // Pin synchronisers: lines plus the two overload sense inputs
    logic [N_LINES+1:0] sync1_reg;
    logic [N_LINES+1:0] sync2_reg;
    logic [N_LINES+1:0] sync3_reg;
    logic [N_LINES+1:0] stable_reg;
    logic [N_LINES+1:0] stable_next;
    logic reduced_reg;
    logic fast_tick;
    logic std_tick;
    logic fast_tick_reg;
    logic std_tick_reg;
    logic [N_LINES-1:0] dir_reg;
    logic [N_LINES-1:0] dir_next;
    logic [N_LINES-1:0] wr_reg;
    logic [N_LINES-1:0] wr_next;
    logic [N_LINES-1:0] rd_reg;
    logic [N_LINES-1:0] rd_next;
    logic [NB-1:0] std_drv_reg;
    logic [NB-1:0] std_drv_next;
    logic [NS-1:0] std_dest_reg;
    logic [NS-1:0] std_dest_next;
    logic trip_reg;
    logic trip_next;
    logic [N_LINES-1:0] oe_reg;
    logic [N_LINES-1:0] oe_next;
    logic [N_LINES-1:0] out_reg;
    logic [N_LINES-1:0] out_next;
    logic aux_en_reg;

    // A bit counts as changed only when the second and third stages agree
    assign stable_next = (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg ^ sync3_reg));
    wire logic [N_LINES-1:0] line_state = stable_reg[N_LINES-1:0];
    wire logic overload_seen = stable_reg[N_LINES] | stable_reg[N_LINES+1];

    // Standard path claims: lines one to four may be outputs, five to eight never
    wire logic [NB-1:0] std_out_low = STD_ROUTED[NB-1:0] & STD_OUTPUT_SELECT;
    wire logic [N_LINES-1:0] std_claim = {{(N_LINES-NS){1'b0}}, STD_ROUTED};
    wire logic [N_LINES-1:0] std_out = {{(N_LINES-NB){1'b0}}, std_out_low};
    wire logic [N_LINES-1:0] std_val = {{(N_LINES-NB){1'b0}}, std_drv_reg};

    // Fast path samples its words on its own refresh tick
    assign dir_next = fast_tick ? DIRECTION_WORD : dir_reg;
    assign wr_next = fast_tick ? OUTPUT_VALUE_WORD : wr_reg;
    assign rd_next = fast_tick ? line_state : rd_reg;

    // Standard path transfers, inverted per line; unrouted inputs report zero
    assign std_drv_next = std_tick ? (STD_SOURCE_VALUE ^ STD_INVERT[NB-1:0]) : std_drv_reg;
    assign std_dest_next = std_tick ? ((line_state[NS-1:0] ^ STD_INVERT) & STD_ROUTED) : std_dest_reg;

    // Overload trip is sticky; an overload present in the clear cycle wins
    assign trip_next = overload_seen | (trip_reg & ~TRIP_CLEAR);

    // Pin drive: standard outputs first, else unclaimed lines with direction set
    assign oe_next = trip_reg ? {N_LINES{1'b0}} : (std_out | (~std_claim & dir_reg));
    assign out_next = trip_reg ? {N_LINES{1'b0}} : ((std_out & std_val) | (~std_claim & dir_reg & wr_reg));

    // Same-clock strap capture; refresh period follows the latest value
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            reduced_reg <= 1'b0;
        else
            reduced_reg <= REDUCED_HOST;
    end

    // Fast refresh timer
    dio_tick_gen #(
        .CNT_W(DIO_CNT_W),
        .PERIOD_NORMAL(DIO_CNT_W'(FAST_CYC)),
        .PERIOD_REDUCED(DIO_CNT_W'(FAST_RED_CYC))
    ) u_fast_tick (
        .clk(CLK),
        .reset_n(RESET_N),
        .reduced(reduced_reg),
        .tick(fast_tick)
    );

    // Standard refresh timer
    dio_tick_gen #(
        .CNT_W(DIO_CNT_W),
        .PERIOD_NORMAL(DIO_CNT_W'(STD_CYC)),
        .PERIOD_REDUCED(DIO_CNT_W'(STD_RED_CYC))
    ) u_std_tick (
        .clk(CLK),
        .reset_n(RESET_N),
        .reduced(reduced_reg),
        .tick(std_tick)
    );

    // Three-stage synchronisers and agreement filter
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            stable_reg <= '0;
        end
        else
        begin
            sync1_reg <= {AUX_OVERLOAD, LINE_OVERLOAD, LINE_IN};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            stable_reg <= stable_next;
        end
    end

    // Fast path words; direction clears at reset so all lines but standard outputs on lines one to four start as inputs
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            dir_reg <= DIO_WORD_RST;
            wr_reg <= DIO_WORD_RST;
            rd_reg <= DIO_WORD_RST;
        end
        else
        begin
            dir_reg <= dir_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Standard path data
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            std_drv_reg <= DIO_BYTE_RST[NB-1:0];
            std_dest_reg <= DIO_BYTE_RST;
        end
        else
        begin
            std_drv_reg <= std_drv_next;
            std_dest_reg <= std_dest_next;
        end
    end

    // Pin drive, trip and strobes; positive logic straight to the pins
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            trip_reg <= 1'b0;
            oe_reg <= DIO_WORD_RST;
            out_reg <= DIO_WORD_RST;
            fast_tick_reg <= 1'b0;
            std_tick_reg <= 1'b0;
            aux_en_reg <= 1'b1; // Own flop, so the supply enable pin is never fed through a gate
        end
        else
        begin
            trip_reg <= trip_next;
            oe_reg <= oe_next;
            out_reg <= out_next;
            fast_tick_reg <= fast_tick;
            std_tick_reg <= std_tick;
            aux_en_reg <= ~trip_next;
        end
    end

    assign LINE_STATE_WORD = rd_reg;
    assign STD_DEST_VALUE = std_dest_reg;
    assign LINE_OUT = out_reg;
    assign LINE_OE = oe_reg;
    assign OVERLOAD_TRIP = trip_reg;
    assign AUX_SUPPLY_OUTPUT_EN = aux_en_reg;
    assign FAST_REFRESH = fast_tick_reg;
    assign STD_REFRESH = std_tick_reg;
endmodule // dio_port

// >>> core/dio_tick_gen.sv
`timescale 1ns/1ps
// Periodic refresh tick; period chosen by the reduced host strap
module dio_tick_gen
#(
    parameter int CNT_W = 32,
    parameter logic [CNT_W-1:0] PERIOD_NORMAL = 32'h00000010,
    parameter logic [CNT_W-1:0] PERIOD_REDUCED = 32'h00000020
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic reduced,
    // Result
    output logic tick
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic tick_reg;
    logic tick_next;
    wire logic [CNT_W-1:0] last_count = (reduced ? PERIOD_REDUCED : PERIOD_NORMAL) - {{(CNT_W-1){1'b0}}, 1'b1};
    // A change of strap mid-period is caught by the >= so the count never runs away
    wire logic at_end = (count_reg >= last_count);

    assign count_next = at_end ? {CNT_W{1'b0}} : count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    assign tick_next = at_end;
    assign tick = tick_reg;

    // Free-running period counter
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= {CNT_W{1'b0}};
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end
endmodule // dio_tick_gen

// >>> sim/dio_host_model.sv
`timescale 1ns/1ps
// Host processor holding the two selected fast-path words
module dio_host_model
(
    // Clock and refresh strobe
    input wire logic clk,
    input wire logic fast_refresh,
    // Selected words, full width so every line is reachable
    output logic [31:0] direction_word,
    output logic [31:0] output_value_word,
    output logic timed_out
);
    // Words start cleared so nothing is driven before the host decides
    initial
    begin
        direction_word = 32'h0;
        output_value_word = 32'h0;
        timed_out = 1'b0;
    end
    // Words change just after a refresh, never while one is being sampled, or at the 200-clock time-out
    task automatic set_words(input logic [31:0] dir, input logic [31:0] val);
        int n;
        n = 0;
        while (fast_refresh !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        timed_out = (n >= 200);
        direction_word = dir;
        output_value_word = val;
    endtask
endmodule // dio_host_model

// >>> sim/dio_port_props.sv
`timescale 1ns/1ps
// Port checks on refresh timing, drive and protection
module dio_port_props
#(
    parameter int FAST_CYC = 20,
    parameter int FAST_RED_CYC = 40,
    parameter int STD_CYC = 50
)
(
    // Watched ports
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic REDUCED_HOST,
    input wire logic OVERLOAD_TRIP,
    input wire logic AUX_SUPPLY_OUTPUT_EN,
    input wire logic FAST_REFRESH,
    input wire logic STD_REFRESH,
    input wire logic [7:0] STD_ROUTED,
    input wire logic [3:0] STD_OUTPUT_SELECT,
    input wire logic [31:0] DIRECTION_WORD,
    input wire logic [31:0] OUTPUT_VALUE_WORD,
    input wire logic [31:0] LINE_IN,
    input wire logic [31:0] LINE_OUT,
    input wire logic [31:0] LINE_OE,
    input wire logic [31:0] LINE_STATE_WORD
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Fast refresh whose drive is not overridden by trip or standard claims
    sequence s_plain_fast;
        FAST_REFRESH && !OVERLOAD_TRIP && STD_ROUTED == 8'h00 ##1 !OVERLOAD_TRIP && STD_ROUTED == 8'h00;
    endsequence
    // Standard settings left alone long enough for pins to follow
    sequence s_std_steady;
        ($stable(STD_ROUTED) && $stable(STD_OUTPUT_SELECT) && !OVERLOAD_TRIP)[*3];
    endsequence
    a_fast_period: assert property (disable iff (!RESET_N || REDUCED_HOST) FAST_REFRESH |-> ##FAST_CYC FAST_REFRESH)
        else $error("fast refresh period wrong");
    a_reduced_period: assert property (disable iff (!RESET_N || !REDUCED_HOST) FAST_REFRESH |-> ##FAST_RED_CYC FAST_REFRESH)
        else $error("reduced fast period wrong");
    a_std_period: assert property (disable iff (!RESET_N || REDUCED_HOST) STD_REFRESH |-> ##STD_CYC STD_REFRESH)
        else $error("standard refresh period wrong");
    a_drive_words: assert property (s_plain_fast |-> LINE_OE == $past(DIRECTION_WORD, 2)
        && (LINE_OUT & LINE_OE) == ($past(DIRECTION_WORD, 2) & $past(OUTPUT_VALUE_WORD, 2))) else $error("drive mismatch");
    a_state_capture: assert property ($stable(LINE_IN)[*8] ##1 FAST_REFRESH |-> LINE_STATE_WORD == $past(LINE_IN))
        else $error("read word mismatch");
    a_std_claim: assert property (s_std_steady |-> (LINE_OE[3:0] & STD_ROUTED[3:0]) == (STD_OUTPUT_SELECT & STD_ROUTED[3:0])
        && (LINE_OE[7:4] & STD_ROUTED[7:4]) == 4'h0) else $error("standard claim drive wrong");
    a_trip_off: assert property (OVERLOAD_TRIP ##1 OVERLOAD_TRIP |-> LINE_OE == 32'h0 && !AUX_SUPPLY_OUTPUT_EN)
        else $error("outputs on during trip");
    a_reset_idle: assert property ($rose(RESET_N) |-> (LINE_OE[31:4] == 28'h0)[*8])
        else $error("line driven after reset");
endmodule // dio_port_props

bind dio_port dio_port_props #(.FAST_CYC(FAST_CYC), .FAST_RED_CYC(FAST_RED_CYC), .STD_CYC(STD_CYC)) u_props
    (.CLK, .RESET_N, .REDUCED_HOST, .OVERLOAD_TRIP, .AUX_SUPPLY_OUTPUT_EN, .FAST_REFRESH, .STD_REFRESH, .STD_ROUTED,
    .STD_OUTPUT_SELECT, .DIRECTION_WORD, .OUTPUT_VALUE_WORD, .LINE_IN, .LINE_OUT, .LINE_OE, .LINE_STATE_WORD);

// >>> sim/dual_rate_digital_io_port_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the dual-rate line port
module dual_rate_digital_io_port_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reduced_host = 1'b0;
    logic line_overload = 1'b0;
    logic aux_overload = 1'b0;
    logic trip_clear = 1'b0;
    logic [7:0] std_routed = 8'h00;
    logic [7:0] std_invert = 8'h00;
    logic [3:0] std_output_select = 4'h0;
    logic [3:0] std_source_value = 4'h0;
    logic [31:0] ext = 32'h0;
    logic [31:0] dir_w, val_w, state_w, line_out, line_oe, line_in;
    logic [7:0] dest;
    logic fast_r, std_r, aux_en, trip, host_to;
    int error_cnt = 0;
    int check_count = 0;
    // Clock and wire level: driven lines show the pin, others the outside source
    always #2.5 clk = ~clk;
    assign line_in = (line_oe & line_out) | (~line_oe & ext);
    dio_host_model u_host (.clk(clk), .fast_refresh(fast_r), .direction_word(dir_w), .output_value_word(val_w),
        .timed_out(host_to));
    dio_port #(.FAST_CYC(20), .FAST_RED_CYC(40), .STD_CYC(50), .STD_RED_CYC(90)) u_dut (.CLK(clk), .RESET_N(reset_n),
        .REDUCED_HOST(reduced_host), .DIRECTION_WORD(dir_w), .OUTPUT_VALUE_WORD(val_w), .LINE_STATE_WORD(state_w),
        .STD_ROUTED(std_routed), .STD_INVERT(std_invert), .STD_OUTPUT_SELECT(std_output_select),
        .STD_SOURCE_VALUE(std_source_value), .STD_DEST_VALUE(dest), .LINE_IN(line_in), .LINE_OUT(line_out),
        .LINE_OE(line_oe), .LINE_OVERLOAD(line_overload), .AUX_OVERLOAD(aux_overload), .TRIP_CLEAR(trip_clear),
        .AUX_SUPPLY_OUTPUT_EN(aux_en), .OVERLOAD_TRIP(trip), .FAST_REFRESH(fast_r), .STD_REFRESH(std_r));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait for a number of refresh pulses; running out ends the run
    task automatic wait_pulse(input bit std, input int n);
        int k;
        k = 0;
        while (n > 0 && k < 2000)
        begin
            @(negedge clk);
            k++;
            if ((std ? std_r : fast_r) === 1'b1)
                n--;
        end
        if (n > 0)
        begin
            error_cnt++;
            $display("BAD refresh pulse expected 1 seen 0");
            stop_test();
        end
    endtask
    task automatic period(input bit std, input logic [31:0] exp);
        int k;
        wait_pulse(std, 1);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end
        while ((std ? std_r : fast_r) !== 1'b1 && k < 500);
        check("refresh period", exp, 32'(k));
    endtask
    // Second pulse is the first capture after the new drive reached the pins
    task automatic run_fast(input logic [31:0] dir, val, e, oe, st);
        ext = e;
        u_host.set_words(dir, val);
        check("host wait", 32'h0, {31'h0, host_to});
        wait_pulse(1'b0, 2);
        check("drive enable", oe, line_oe);
        check("driven level", st & oe, line_out & line_oe);
        check("read word", st, state_w);
        $display("fast test done");
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        run_fast(32'h0000001d, 32'h00000017, 32'h0, 32'h0000001d, 32'h00000015);
        run_fast(32'h40000000, 32'hffffffff, 32'h80000000, 32'h40000000, 32'hc0000000);
        // Line one driven by the standard path, lines two and five claimed inputs
        std_routed = 8'h13;
        std_output_select = 4'h1;
        std_invert = 8'h01;
        // New invert reaches the standard drive only at a standard refresh
        wait_pulse(1'b1, 1);
        run_fast(32'hffffffff, 32'h0, 32'h00000012, 32'hffffffed, 32'h00000013);
        wait_pulse(1'b1, 2);
        check("std dest", 32'h12, {24'h0, dest});
        // Source one with invert one drives line one low; pins follow a cycle after the refresh
        std_source_value = 4'h1;
        wait_pulse(1'b1, 1);
        @(negedge clk);
        check("std source drive", 32'h0, {31'h0, line_out[0]});
        std_routed = 8'h00;
        // Each overload source trips; removing it and clearing restores the supply
        for (int k = 0; k < 2; k++)
        begin
            {aux_overload, line_overload} = k ? 2'b10 : 2'b01;
            repeat (8) @(negedge clk);
            check("trip", 32'h1, {31'h0, trip});
            check("pins off", 32'h0, line_oe | {31'h0, aux_en});
            {aux_overload, line_overload} = 2'b00;
            trip_clear = 1'b1;
            repeat (8) @(negedge clk);
            trip_clear = 1'b0;
            check("aux on", 32'h1, {31'h0, aux_en});
        end
        $display("overload test done");
        period(1'b0, 32'd20);
        period(1'b1, 32'd50);
        wait_pulse(1'b0, 1);
        reduced_host = 1'b1;
        period(1'b0, 32'd40);
        period(1'b1, 32'd90);
        $display("period test done");
        reset_n = 1'b0;
        reduced_host = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        repeat (10) @(negedge clk);
        check("idle drive", 32'h0, line_oe);
        $display("reset test done");
        stop_test();
    end
endmodule // dual_rate_digital_io_port_bench
